/* rtl/gacr_consts.vh */
// register offsets, field positions and reset values of the amplifier control block
`ifndef GACR_CONSTS_VH
`define GACR_CONSTS_VH
`define GACR_ADDR_W 8
`define GACR_OFF_AMP1_CTRL 8'h1B
`define GACR_OFF_AMP2_CTRL 8'h1C
`define GACR_OFF_AMP3_PWR 8'h1D
`define GACR_OFF_CMP_IRQ 8'h1E
`define GACR_OFF_REF_CTRL 8'h1F
`define GACR_RESET_VAL 8'h00
`define GACR_BIT_OFFSET_NULL 7
`define GACR_GAIN_HI 6
`define GACR_GAIN_LO 4
`define GACR_POS_HI 3
`define GACR_POS_LO 2
`define GACR_NEG_HI 1
`define GACR_NEG_LO 0
`define GACR_BIT_AMP3_ON 7
`define GACR_BIT_IE1 7
`define GACR_BIT_POL1 6
`define GACR_BIT_LVL1 5
`define GACR_BIT_ON1 4
`define GACR_BIT_IE2 3
`define GACR_BIT_POL2 2
`define GACR_BIT_LVL2 1
`define GACR_BIT_ON2 0
`define GACR_BIT_REF2_EN 7
`define GACR_REF2_HI 6
`define GACR_REF2_LO 4
`define GACR_BIT_REF1_EN 3
`define GACR_REF1_HI 2
`define GACR_REF1_LO 0
`define GACR_POS_STEP_REF 2'h0
`define GACR_POS_PIN 2'h1
`define GACR_POS_BANDGAP 2'h2
`define GACR_POS_FLOAT 2'h3
`define GACR_NEG_AGND 2'h0
`define GACR_NEG_FLOAT 2'h1
`define GACR_GAIN_COMPARATOR 3'h7
`endif

/* rtl/gacr_regs.v */
// control and status registers of the programmable gain amplifier module
// Operation
// (R1) amp two offset-null flag at bit 7
// (R2) amp two gain code decoded, 111 comparator
// (R3) amp two positive input select, four sources
// (R4) amp two negative input: ground, float, pin
// (R5) amp three power bit 7, rest reserved
// (R6) software keeps amp three off when absent
// (R7) irq one needs enable and level match
// (R8) polarity bit one sets triggering level
// (R9) read-only filtered level one at bit 5
// (R10) amp one power switch at bit 4
// (R11) amp two fields in low nibble
// (R12) all power bits zero disables module
// (R13) ref two enable picks ground or ref
// (R14) ref two level in eighths of supply
// (R15) ref one enable picks ground or ref
// (R16) ref one level in eighths of supply
// (R17) both ref enables clear disable generator
// (R18) five registers consecutive, reset to zero
// (R19) amp one control mirrors amp two fields
// (R20) irq request is a level, not latched
// (R21) separate irq line per gain amp
// (R22) either irq may wake the processor
// (R23) power bits follow field descriptions
// (R24) comparator outputs pass two-flop synchroniser
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gacr_consts.vh"
module gacr_regs (
  // clock, reset, enable
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  // comparator outputs from the analog side
  input wire [1:0] cmp_out_raw,
  // amplifier one controls
  output reg offset_null_en_1,
  output reg [2:0] gain_sel_1,
  output reg [1:0] pos_input_sel_1,
  output reg [1:0] neg_input_sel_1,
  output reg comparator_mode_1,
  output reg amp_one_power,
  // amplifier two controls
  output reg offset_null_en_2,
  output reg [2:0] gain_sel_2,
  output reg [1:0] pos_input_sel_2,
  output reg [1:0] neg_input_sel_2,
  output reg comparator_mode_2,
  output reg amp_two_power,
  // stand-alone amplifier and module power
  output reg standalone_amp_power,
  output reg module_enable,
  // reference generator
  output reg ref_one_enable,
  output reg [2:0] ref_one_level,
  output reg ref_two_enable,
  output reg [2:0] ref_two_level,
  output reg ref_gen_enable,
  output reg [1:0] pos_ref_connect,
  // interrupt requests, wake capable
  output reg cmp1_irq,
  output reg cmp2_irq
);

  reg [7:0] amp1_control_reg;
  reg [7:0] amp2_control_reg;
  reg amp3_power_reg;
  reg [7:0] irq_ctrl_reg;
  reg [7:0] ref_control_reg;
  reg [1:0] sync1_reg;
  reg [1:0] sync2_reg;
  reg [7:0] rdata_next;
  wire [1:0] cmp_level;
  wire [7:0] irq_view;
  wire [1:0] irq_next;

  // two-flop synchroniser per comparator
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else if (clk_en) begin
      sync1_reg <= cmp_out_raw; // R24
      sync2_reg <= sync1_reg; // R24
    end
  end

  assign cmp_level = sync2_reg;

  // status view: levels replace the stored bits
  assign irq_view = {irq_ctrl_reg[7:6], cmp_level[0], irq_ctrl_reg[4:2], cmp_level[1], irq_ctrl_reg[0]}; // R9 R11

  // level request per amplifier
  assign irq_next[0] = irq_ctrl_reg[`GACR_BIT_IE1] & (cmp_level[0] == irq_ctrl_reg[`GACR_BIT_POL1]); // R7 R8 R20
  assign irq_next[1] = irq_ctrl_reg[`GACR_BIT_IE2] & (cmp_level[1] == irq_ctrl_reg[`GACR_BIT_POL2]); // R11 R20

  // register writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp1_control_reg <= `GACR_RESET_VAL; // R18
      amp2_control_reg <= `GACR_RESET_VAL;
      amp3_power_reg <= 1'b0;
      irq_ctrl_reg <= `GACR_RESET_VAL;
      ref_control_reg <= `GACR_RESET_VAL;
    end else if (clk_en && wr_en) begin
      case (addr)
        `GACR_OFF_AMP1_CTRL: amp1_control_reg <= wdata; // R19
        `GACR_OFF_AMP2_CTRL: amp2_control_reg <= wdata; // R1
        `GACR_OFF_AMP3_PWR: amp3_power_reg <= wdata[`GACR_BIT_AMP3_ON]; // R5
        `GACR_OFF_CMP_IRQ: irq_ctrl_reg <= wdata & 8'hDD; // R9 R23
        `GACR_OFF_REF_CTRL: ref_control_reg <= wdata;
        default: amp1_control_reg <= amp1_control_reg;
      endcase
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    rdata_next = 8'h00;
    case (addr)
      `GACR_OFF_AMP1_CTRL: rdata_next = amp1_control_reg;
      `GACR_OFF_AMP2_CTRL: rdata_next = amp2_control_reg;
      `GACR_OFF_AMP3_PWR: rdata_next = {amp3_power_reg, 7'h00}; // R5
      `GACR_OFF_CMP_IRQ: rdata_next = irq_view; // R9
      `GACR_OFF_REF_CTRL: rdata_next = ref_control_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // registered outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
      offset_null_en_1 <= 1'b0;
      gain_sel_1 <= 3'h0;
      pos_input_sel_1 <= 2'h0;
      neg_input_sel_1 <= 2'h0;
      comparator_mode_1 <= 1'b0;
      amp_one_power <= 1'b0;
      offset_null_en_2 <= 1'b0;
      gain_sel_2 <= 3'h0;
      pos_input_sel_2 <= 2'h0;
      neg_input_sel_2 <= 2'h0;
      comparator_mode_2 <= 1'b0;
      amp_two_power <= 1'b0;
      standalone_amp_power <= 1'b0;
      module_enable <= 1'b0;
      ref_one_enable <= 1'b0;
      ref_one_level <= 3'h0;
      ref_two_enable <= 1'b0;
      ref_two_level <= 3'h0;
      ref_gen_enable <= 1'b0;
      pos_ref_connect <= 2'h0;
      cmp1_irq <= 1'b0;
      cmp2_irq <= 1'b0;
    end else if (clk_en) begin
      if (rd_en) begin
        rdata <= rdata_next;
      end
      offset_null_en_1 <= amp1_control_reg[`GACR_BIT_OFFSET_NULL]; // R19
      gain_sel_1 <= amp1_control_reg[`GACR_GAIN_HI:`GACR_GAIN_LO]; // R19
      pos_input_sel_1 <= amp1_control_reg[`GACR_POS_HI:`GACR_POS_LO]; // R19
      neg_input_sel_1 <= amp1_control_reg[`GACR_NEG_HI:`GACR_NEG_LO]; // R19
      comparator_mode_1 <= amp1_control_reg[`GACR_GAIN_HI:`GACR_GAIN_LO] == `GACR_GAIN_COMPARATOR; // R2
      amp_one_power <= irq_ctrl_reg[`GACR_BIT_ON1]; // R10 R23
      offset_null_en_2 <= amp2_control_reg[`GACR_BIT_OFFSET_NULL]; // R1
      gain_sel_2 <= amp2_control_reg[`GACR_GAIN_HI:`GACR_GAIN_LO]; // R2
      pos_input_sel_2 <= amp2_control_reg[`GACR_POS_HI:`GACR_POS_LO]; // R3
      neg_input_sel_2 <= amp2_control_reg[`GACR_NEG_HI:`GACR_NEG_LO]; // R4
      comparator_mode_2 <= amp2_control_reg[`GACR_GAIN_HI:`GACR_GAIN_LO] == `GACR_GAIN_COMPARATOR; // R2
      amp_two_power <= irq_ctrl_reg[`GACR_BIT_ON2]; // R11 R23
      standalone_amp_power <= amp3_power_reg; // R5
      module_enable <= amp3_power_reg | irq_ctrl_reg[`GACR_BIT_ON1] | irq_ctrl_reg[`GACR_BIT_ON2]; // R12
      ref_one_enable <= ref_control_reg[`GACR_BIT_REF1_EN];
      ref_one_level <= ref_control_reg[`GACR_REF1_HI:`GACR_REF1_LO]; // R16
      ref_two_enable <= ref_control_reg[`GACR_BIT_REF2_EN];
      ref_two_level <= ref_control_reg[`GACR_REF2_HI:`GACR_REF2_LO]; // R14
      ref_gen_enable <= ref_control_reg[`GACR_BIT_REF1_EN] | ref_control_reg[`GACR_BIT_REF2_EN]; // R17
      // positive input tied to reference only when stepped source chosen and enabled
      pos_ref_connect[0] <= (amp1_control_reg[`GACR_POS_HI:`GACR_POS_LO] == `GACR_POS_STEP_REF) &
                            ref_control_reg[`GACR_BIT_REF1_EN]; // R15
      pos_ref_connect[1] <= (amp2_control_reg[`GACR_POS_HI:`GACR_POS_LO] == `GACR_POS_STEP_REF) &
                            ref_control_reg[`GACR_BIT_REF2_EN]; // R13
      cmp1_irq <= irq_next[0]; // R21 R22
      cmp2_irq <= irq_next[1]; // R21 R22
    end
  end

endmodule // gacr_regs
`default_nettype wire

/* test/gacr_analog.sv */
// analog side model: comparator outputs
`timescale 1ns/1ps
`default_nettype none
module gacr_analog (
  // comparator levels asked by the bench
  input wire logic [1:0] lvl_set,
  // outputs move off the clock edge
  output logic [1:0] cmp_out_raw
);
  initial cmp_out_raw = 2'h0;
  always @(lvl_set) cmp_out_raw <= #3 lvl_set;
endmodule // gacr_analog
`default_nettype wire

/* test/gacr_regs_sva.sv */
// assertions on the amplifier control register ports
`timescale 1ns/1ps
`default_nettype none
module gacr_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // analog side and controls
  input wire logic [1:0] cmp_out_raw,
  input wire logic offset_null_en_2,
  input wire logic [2:0] gain_sel_2,
  input wire logic [1:0] pos_input_sel_2,
  input wire logic [1:0] neg_input_sel_2,
  input wire logic comparator_mode_2,
  input wire logic amp_one_power,
  input wire logic amp_two_power,
  input wire logic standalone_amp_power,
  input wire logic module_enable,
  input wire logic ref_one_enable,
  input wire logic ref_two_enable,
  input wire logic ref_gen_enable,
  input wire logic [1:0] pos_ref_connect,
  input wire logic cmp1_irq,
  input wire logic cmp2_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  pwr_or_a: assert property (module_enable == (amp_one_power | amp_two_power | standalone_amp_power))
    else $error("module enable wrong");
  ref_or_a: assert property (ref_gen_enable == (ref_one_enable | ref_two_enable))
    else $error("ref generator enable wrong");
  cmp_mode_a: assert property (comparator_mode_2 == (gain_sel_2 == 3'h7))
    else $error("comparator mode wrong");
  pos_ref_a: assert property (pos_ref_connect[1] == (pos_input_sel_2 == 2'h0 && ref_two_enable))
    else $error("ref two connect wrong");
  rd_unmap_a: assert property (rd_en && clk_en && (addr < 8'h1B || addr > 8'h1F) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_amp3_a: assert property (rd_en && clk_en && addr == 8'h1D |=> rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");
  wr_amp2_a: assert property (wr_en && clk_en && addr == 8'h1C ##1 clk_en |=>
    {offset_null_en_2, gain_sel_2, pos_input_sel_2, neg_input_sel_2} == $past(wdata, 2))
    else $error("amp two fields wrong");
  irq_sync_a: assert property ((resetn && clk_en && !wr_en)[*5] ##0 $changed(cmp1_irq) |->
    $past(cmp_out_raw[0], 3) != $past(cmp_out_raw[0], 4))
    else $error("irq moved without level change");
  cover property (cmp1_irq && cmp2_irq);
  cover property (rd_en && addr == 8'h1E);
  cover property (wr_en && addr == 8'h1C);
endmodule // gacr_regs_chk
bind gacr_regs gacr_regs_chk i_gacr_regs_chk (.*);
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the amplifier control registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, resetn, clk_en, wr_en, rd_en;
  logic [7:0] addr, wdata, v;
  logic [1:0] lvl_set;
  logic [7:0] exp_q[$];
  wire [1:0] cmp_out_raw;
  wire [7:0] rdata;
  wire p1, p2, p3, m_en, irq1, irq2;
  wire az1, cm1, r1e, r2e, rg_en;
  wire [2:0] g1, r1l, r2l;
  wire [1:0] ps1, ns1, prc;
  logic [7:0] u;
  int miscompares, tests_run;
  gacr_analog i_gacr_analog (.lvl_set(lvl_set), .cmp_out_raw(cmp_out_raw));
  gacr_regs i_gacr_regs (.clk(clk), .resetn(resetn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cmp_out_raw(cmp_out_raw), .offset_null_en_1(az1),
    .gain_sel_1(g1), .pos_input_sel_1(ps1), .neg_input_sel_1(ns1), .comparator_mode_1(cm1), .amp_one_power(p1),
    .offset_null_en_2(), .gain_sel_2(), .pos_input_sel_2(), .neg_input_sel_2(), .comparator_mode_2(),
    .amp_two_power(p2), .standalone_amp_power(p3), .module_enable(m_en), .ref_one_enable(r1e),
    .ref_one_level(r1l), .ref_two_enable(r2e), .ref_two_level(r2l), .ref_gen_enable(rg_en),
    .pos_ref_connect(prc), .cmp1_irq(irq1), .cmp2_irq(irq2));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  always @(posedge clk) begin
    if (rd_en && exp_q.size() > 0) begin
      @(negedge clk);
      chk(rdata, exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    miscompares++;
    end_of_test;
  end
  initial begin
    {resetn, wr_en, rd_en, addr, wdata, lvl_set} = '0;
    clk_en = 1'b1;
    miscompares = 0;
    tests_run = 0;
    v = $urandom(32'h03470983);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 8'h1A; a <= 8'h20; a++) rd(a[7:0], 8'h00);
    for (int a = 8'h1B; a <= 8'h1F; a++) begin
      v = $urandom;
      wr(a[7:0], v);
      rd(a[7:0], a == 8'h1D ? v & 8'h80 : a == 8'h1E ? v & 8'hDD : v);
    end
    wr(8'h20, 8'hFF);
    rd(8'h1F, v);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      u = $urandom;
      v[6:4] = i[2:0];
      v[3:2] = i[1:0];
      u[3] = i[2];
      wr(8'h1B, v);
      wr(8'h1F, u);
      repeat (2) @(posedge clk);
      chk_pins({az1, g1, ps1, ns1}, v);
      chk_pins(cm1, i[2:0] == 3'h7);
      chk_pins({r2e, r2l, r1e, r1l}, u);
      chk_pins(rg_en, u[7] | u[3]);
      chk_pins(prc[0], v[3:2] == 2'h0 && u[3]);
    end
    // a write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(8'h1B, ~v);
    clk_en <= 1'b1;
    rd(8'h1B, v);
    for (int i = 0; i < 8; i++) begin
      wr(8'h1D, {i[2], 7'h00});
      wr(8'h1E, {3'h0, i[0], 3'h0, i[1]});
      repeat (2) @(posedge clk);
      chk_pins({m_en, p3, p2, p1}, {i[2:0] != 0, i[2], i[1], i[0]});
    end
    wr(8'h1D, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      lvl_set <= i[1:0];
      wr(8'h1E, {1'b1, i[2], v[5], 2'h3, i[3], v[1], 1'b1});
      repeat (6) @(posedge clk);
      chk_pins({irq2, irq1}, {i[1] == i[3], i[0] == i[2]});
      rd(8'h1E, {1'b1, i[2], i[0], 2'h3, i[3], i[1], 1'b1});
    end
    lvl_set <= 2'h0;
    repeat (6) @(posedge clk);
    chk_pins({irq2, irq1}, 2'h0);
    lvl_set <= 2'h3;
    repeat (6) @(posedge clk);
    chk_pins({irq2, irq1}, 2'h3);
    wr(8'h1E, 8'h00);
    repeat (2) @(posedge clk);
    chk_pins({irq2, irq1}, 2'h0);
    // second reset in mid-run clears every register
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h1B, 8'h00);
    chk_pins({az1, g1, ps1, ns1}, 8'h00);
    repeat (3) @(posedge clk);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
